// File: core/cpm_pkg.sv
// constants, types and register map of the counter measurement block
//Contract
// - period mode: once armed, measure one gate period between like active edges
// - count the chosen source edges between the two active gate edges, return it
// - position counting starts only after software arms the counter
// - single edge decode: up on A rise with A leading, down on A fall
// - double edge decode: step on both A edges, direction from leading channel
// - quad edge decode: step on every A and B edge, four per cycle
// - index high in the programmed quadrature phase loads the reload value
// - a count step due with a reload is applied first, reload follows
// - reload lands within one timebase period, then counting resumes
// - two-pulse mode: up on every A rise, down on every B rise
// - buffered position: capture count on each sample edge, stream it out
// - sample edges never clear the count; values accumulate from arming
// - sample clock enters on the gate input, rising or falling selectable
package cpm_pkg;
	// ************************************************************
	// register map
	// ************************************************************
	localparam int          ADDR_W      = 8;
	localparam int          DATA_W      = 32;
	localparam logic [7:0]  ADDR_CTRL   = 8'h00;
	localparam logic [7:0]  ADDR_ARM    = 8'h04;
	localparam logic [7:0]  ADDR_RELOAD = 8'h08;
	localparam logic [7:0]  ADDR_COUNT  = 8'h0c;
	localparam logic [7:0]  ADDR_PERIOD = 8'h10;
	localparam logic [7:0]  ADDR_STATUS = 8'h14;

	// ************************************************************
	// control fields
	// ************************************************************
	localparam int          CTRL_W      = 10;
	localparam int          MODE_LSB    = 0;
	localparam int          DEC_LSB     = 2;
	localparam int          GATE_FALL   = 4;
	localparam int          SRC_FALL    = 5;
	localparam int          BUFFERED    = 6;
	localparam int          ZEN         = 7;
	localparam int          ZPH_LSB     = 8;
	localparam logic [9:0]  CTRL_RST    = 10'h000;
	localparam logic [31:0] RELOAD_RST  = 32'h0000_0000;
	localparam int          ARM_BIT     = 0;
	localparam int          DISARM_BIT  = 1;

	// ************************************************************
	// status fields
	// ************************************************************
	localparam int          ST_ARMED    = 0;
	localparam int          ST_PDONE    = 1;
	localparam int          ST_OVF      = 2;
	localparam int          ST_MEAS     = 3;

	// ************************************************************
	// input lanes of the synchroniser
	// ************************************************************
	localparam int          N_IN        = 5;
	localparam int          IN_GATE     = 0;
	localparam int          IN_SRC      = 1;
	localparam int          IN_A        = 2;
	localparam int          IN_B        = 3;
	localparam int          IN_Z        = 4;

	// ************************************************************
	// types
	// ************************************************************
	typedef enum logic [1:0] {
		MODE_PERIOD    = 2'h0,
		MODE_QUAD      = 2'h1,
		MODE_TWO_PULSE = 2'h2,
		MODE_RSVD      = 2'h3
	} cpm_mode_t;

	typedef enum logic [1:0] {
		single_edge_decode = 2'h0,
		double_edge_decode = 2'h1,
		quad_edge_decode   = 2'h2,
		rsvd_decode        = 2'h3
	} cpm_dec_t;

	typedef enum logic [2:0] {
		PST_IDLE = 3'b001,
		PST_WAIT = 3'b010,
		PST_MEAS = 3'b100
	} cpm_pst_t;
endpackage : cpm_pkg

// File: core/cpm_edge_if.sv
// synchronised pin levels and edges passed to the counter core
`timescale 1ns/1ps
interface cpm_edge_if;
	logic [cpm_pkg::N_IN-1:0] lvl;
	logic [cpm_pkg::N_IN-1:0] prev;
	logic [cpm_pkg::N_IN-1:0] rise;
	logic [cpm_pkg::N_IN-1:0] fall;

	modport src (output lvl, output prev, output rise, output fall);
	modport dst (input lvl, input prev, input rise, input fall);
endinterface : cpm_edge_if

// File: core/cpm_in_sync.sv
// two-flop synchronisers and edge detectors for the counter pins
`timescale 1ns/1ps
module cpm_in_sync (
	input  wire logic                    sys_clk,
	input  wire logic                    rst,
	input  wire logic [cpm_pkg::N_IN-1:0] pin_lvl,
	cpm_edge_if.src                      edges
);
	logic [cpm_pkg::N_IN-1:0] s1_reg;
	logic [cpm_pkg::N_IN-1:0] s2_reg;
	logic [cpm_pkg::N_IN-1:0] s3_reg;

	// ************************************************************
	// one synchroniser chain per pin
	// ************************************************************
	genvar i;
	generate
		for (i = 0; i < cpm_pkg::N_IN; i++) begin : g_sync
			// first flop feeds only the second
			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst) begin
					s1_reg[i] <= 1'b0;
					s2_reg[i] <= 1'b0;
					s3_reg[i] <= 1'b0;
				end else begin
					s1_reg[i] <= pin_lvl[i];
					s2_reg[i] <= s1_reg[i];
					s3_reg[i] <= s2_reg[i];
				end
			end
		end
	endgenerate

	// edges from settled stages only
	assign edges.lvl  = s2_reg;
	assign edges.prev = s3_reg;
	assign edges.rise = s2_reg & ~s3_reg;
	assign edges.fall = ~s2_reg & s3_reg;
endmodule : cpm_in_sync

// File: core/cpm_counter.sv
// counter channel for period and encoder position measurement
//
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/1ps
module cpm_counter (
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	input  wire logic        gate_in,
	input  wire logic        source_in,
	input  wire logic        enc_a,
	input  wire logic        enc_b,
	input  wire logic        enc_z,
	input  wire logic        strm_ready,
	output logic             strm_valid,
	output logic      [31:0] strm_data,
	output logic             armed_out
);
	// ************************************************************
	// declarations
	// ************************************************************
	cpm_edge_if edges ();

	logic [cpm_pkg::CTRL_W-1:0] ctrl_reg;
	logic [31:0]                reload_reg;
	logic [31:0]                pos_reg;
	logic [31:0]                pcnt_reg;
	logic [31:0]                period_reg;
	logic [31:0]                rdata_reg;
	logic [31:0]                strm_data_reg;
	logic                       strm_valid_reg;
	logic                       armed_reg;
	logic                       pdone_reg;
	logic                       ovf_reg;
	cpm_pkg::cpm_pst_t          pst_reg;
	cpm_pkg::cpm_pst_t          pst_next;

	cpm_pkg::cpm_mode_t         mode;
	cpm_pkg::cpm_dec_t          dec;
	logic                       buffered;
	logic                       z_en;
	logic [1:0]                 z_phase;
	logic                       gate_act;
	logic                       src_act;
	logic                       arm_wr;
	logic                       disarm_wr;
	logic                       stat_wr;
	logic                       pos_mode;
	logic [1:0]                 ab_cur;
	logic [1:0]                 ab_prev;
	logic                       step_up;
	logic                       step_dn;
	logic                       step;
	logic                       reload_due;
	logic                       period_end;
	logic                       sample;
	logic                       push;
	logic [31:0]                push_data;
	logic                       push_ok;

	// ************************************************************
	// helper functions
	// ************************************************************
	// picks the active edge of one lane
	function automatic logic cpm_sel_edge(
		input logic r,
		input logic f,
		input logic use_fall
	);
		cpm_sel_edge = use_fall ? f : r;
	endfunction : cpm_sel_edge

	// quadrature step, {up, down}; A leads on 00-10-11-01
	function automatic logic [1:0] cpm_quad_step(
		input logic [1:0]        p,
		input logic [1:0]        c,
		input cpm_pkg::cpm_dec_t d
	);
		logic a_edge;
		logic up;
		logic dn;
		a_edge = p[1] ^ c[1];
		up     = (p == 2'h0 && c == 2'h2) || (p == 2'h2 && c == 2'h3) ||
			(p == 2'h3 && c == 2'h1) || (p == 2'h1 && c == 2'h0);
		dn     = (p == 2'h2 && c == 2'h0) || (p == 2'h3 && c == 2'h2) ||
			(p == 2'h1 && c == 2'h3) || (p == 2'h0 && c == 2'h1);
		case (d)
			cpm_pkg::single_edge_decode: begin
				// only A edges with B low
				cpm_quad_step = {up & a_edge & ~c[0], dn & a_edge & ~c[0]};
			end
			cpm_pkg::double_edge_decode: begin
				cpm_quad_step = {up & a_edge, dn & a_edge};
			end
			cpm_pkg::quad_edge_decode: begin
				cpm_quad_step = {up, dn};
			end
			default: begin
				cpm_quad_step = 2'b00;
			end
		endcase
	endfunction : cpm_quad_step

	// ************************************************************
	// input synchronisers
	// ************************************************************
	cpm_in_sync u_sync (
		.sys_clk (sys_clk),
		.rst     (rst),
		.pin_lvl ({enc_z, enc_b, enc_a, source_in, gate_in}),
		.edges   (edges)
	);

	// ************************************************************
	// control decode
	// ************************************************************
	// fields of the control register
	assign mode     = cpm_pkg::cpm_mode_t'(ctrl_reg[cpm_pkg::MODE_LSB +: 2]);
	assign dec      = cpm_pkg::cpm_dec_t'(ctrl_reg[cpm_pkg::DEC_LSB +: 2]);
	assign buffered = ctrl_reg[cpm_pkg::BUFFERED];
	assign z_en     = ctrl_reg[cpm_pkg::ZEN];
	assign z_phase  = ctrl_reg[cpm_pkg::ZPH_LSB +: 2];
	assign pos_mode = (mode == cpm_pkg::MODE_QUAD) || (mode == cpm_pkg::MODE_TWO_PULSE);

	// register strobes
	assign arm_wr    = reg_wr && reg_addr == cpm_pkg::ADDR_ARM && reg_wdata[cpm_pkg::ARM_BIT];
	assign disarm_wr = reg_wr && reg_addr == cpm_pkg::ADDR_ARM && reg_wdata[cpm_pkg::DISARM_BIT];
	assign stat_wr   = reg_wr && reg_addr == cpm_pkg::ADDR_STATUS;

	// active gate and source edges
	assign gate_act = cpm_sel_edge(edges.rise[cpm_pkg::IN_GATE], edges.fall[cpm_pkg::IN_GATE],
		ctrl_reg[cpm_pkg::GATE_FALL]);
	assign src_act  = cpm_sel_edge(edges.rise[cpm_pkg::IN_SRC], edges.fall[cpm_pkg::IN_SRC],
		ctrl_reg[cpm_pkg::SRC_FALL]);

	// ************************************************************
	// configuration registers
	// ************************************************************
	// software writes to control and reload value
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ctrl_reg   <= cpm_pkg::CTRL_RST;
			reload_reg <= cpm_pkg::RELOAD_RST;
		end else if (reg_wr) begin
			case (reg_addr)
				cpm_pkg::ADDR_CTRL: begin
					ctrl_reg <= reg_wdata[cpm_pkg::CTRL_W-1:0];
				end
				cpm_pkg::ADDR_RELOAD: begin
					reload_reg <= reg_wdata;
				end
				default: begin
				end
			endcase
		end
	end

	// ************************************************************
	// arming
	// ************************************************************
	// arm wins over disarm and over a finishing period
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			armed_reg <= 1'b0;
		end else if (arm_wr) begin
			armed_reg <= 1'b1;
		end else if (disarm_wr || period_end) begin
			armed_reg <= 1'b0;
		end
	end

	// ************************************************************
	// period measurement
	// ************************************************************
	assign period_end = (pst_reg == cpm_pkg::PST_MEAS) && gate_act && !disarm_wr;

	// next state of the period sequencer
	always_comb begin
		pst_next = pst_reg;
		case (pst_reg)
			cpm_pkg::PST_IDLE: begin
				pst_next = cpm_pkg::PST_IDLE;
			end
			cpm_pkg::PST_WAIT: begin
				if (gate_act) begin
					pst_next = cpm_pkg::PST_MEAS;
				end
			end
			cpm_pkg::PST_MEAS: begin
				if (gate_act) begin
					pst_next = cpm_pkg::PST_IDLE;
				end
			end
			default: begin
				pst_next = cpm_pkg::PST_IDLE;
			end
		endcase
		if (arm_wr) begin
			pst_next = (mode == cpm_pkg::MODE_PERIOD) ? cpm_pkg::PST_WAIT : cpm_pkg::PST_IDLE;
		end else if (disarm_wr) begin
			pst_next = cpm_pkg::PST_IDLE;
		end
	end

	// sequencer state
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pst_reg <= cpm_pkg::PST_IDLE;
		end else begin
			pst_reg <= pst_next;
		end
	end

	// source edge count between gate edges
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pcnt_reg <= 32'h0000_0000;
		end else if (arm_wr || (pst_reg == cpm_pkg::PST_WAIT && gate_act)) begin
			pcnt_reg <= 32'h0000_0000;
		end else if (pst_reg == cpm_pkg::PST_MEAS && src_act && !gate_act) begin
			pcnt_reg <= pcnt_reg + 32'h0000_0001;
		end
	end

	// result of the last period
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			period_reg <= 32'h0000_0000;
		end else if (period_end) begin
			period_reg <= pcnt_reg;
		end
	end

	// ************************************************************
	// position decoding
	// ************************************************************
	assign ab_cur  = {edges.lvl[cpm_pkg::IN_A], edges.lvl[cpm_pkg::IN_B]};
	assign ab_prev = {edges.prev[cpm_pkg::IN_A], edges.prev[cpm_pkg::IN_B]};

	// per-cycle step request from the selected encoder type
	always_comb begin
		step_up = 1'b0;
		step_dn = 1'b0;
		if (mode == cpm_pkg::MODE_QUAD) begin
			{step_up, step_dn} = cpm_quad_step(ab_prev, ab_cur, dec);
		end else if (mode == cpm_pkg::MODE_TWO_PULSE) begin
			step_up = edges.rise[cpm_pkg::IN_A];
			step_dn = edges.rise[cpm_pkg::IN_B];
		end
	end

	// simultaneous up and down cancel
	assign step = step_up ^ step_dn;

	// index reload waits for a cycle with no step
	assign reload_due = (mode == cpm_pkg::MODE_QUAD) && z_en && edges.lvl[cpm_pkg::IN_Z] &&
		(ab_cur == z_phase) && !step;

	// position count, cleared only by arming
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pos_reg <= 32'h0000_0000;
		end else if (arm_wr) begin
			pos_reg <= 32'h0000_0000;
		end else if (armed_reg && pos_mode) begin
			if (step && step_up) begin
				pos_reg <= pos_reg + 32'h0000_0001;
			end else if (step) begin
				pos_reg <= pos_reg - 32'h0000_0001;
			end else if (reload_due) begin
				pos_reg <= reload_reg;
			end
		end
	end

	// ************************************************************
	// sample clock and output stream
	// ************************************************************
	assign sample    = armed_reg && pos_mode && buffered && gate_act;
	assign push      = sample || period_end;
	assign push_data = period_end ? pcnt_reg : pos_reg;
	assign push_ok   = !strm_valid_reg || strm_ready;

	// single holding stage towards host memory
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			strm_valid_reg <= 1'b0;
			strm_data_reg  <= 32'h0000_0000;
		end else if (push && push_ok) begin
			strm_valid_reg <= 1'b1;
			strm_data_reg  <= push_data;
		end else if (strm_ready) begin
			strm_valid_reg <= 1'b0;
		end
	end

	// ************************************************************
	// sticky status flags
	// ************************************************************
	// set wins over a write-one clear
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pdone_reg <= 1'b0;
		end else if (period_end) begin
			pdone_reg <= 1'b1;
		end else if (stat_wr && reg_wdata[cpm_pkg::ST_PDONE]) begin
			pdone_reg <= 1'b0;
		end
	end

	// sample lost while the stream is stalled
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ovf_reg <= 1'b0;
		end else if (push && !push_ok) begin
			ovf_reg <= 1'b1;
		end else if (stat_wr && reg_wdata[cpm_pkg::ST_OVF]) begin
			ovf_reg <= 1'b0;
		end
	end

	// ************************************************************
	// read port
	// ************************************************************
	// data stand only in the cycle after the read strobe
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rdata_reg <= 32'h0000_0000;
		end else if (reg_rd) begin
			case (reg_addr)
				cpm_pkg::ADDR_CTRL: begin
					rdata_reg <= {22'h00_0000, ctrl_reg};
				end
				cpm_pkg::ADDR_ARM: begin
					rdata_reg <= {31'h0000_0000, armed_reg};
				end
				cpm_pkg::ADDR_RELOAD: begin
					rdata_reg <= reload_reg;
				end
				cpm_pkg::ADDR_COUNT: begin
					rdata_reg <= (mode == cpm_pkg::MODE_PERIOD) ? pcnt_reg : pos_reg;
				end
				cpm_pkg::ADDR_PERIOD: begin
					rdata_reg <= period_reg;
				end
				cpm_pkg::ADDR_STATUS: begin
					rdata_reg <= 32'h0000_0000;
					rdata_reg[cpm_pkg::ST_ARMED] <= armed_reg;
					rdata_reg[cpm_pkg::ST_PDONE] <= pdone_reg;
					rdata_reg[cpm_pkg::ST_OVF]   <= ovf_reg;
					rdata_reg[cpm_pkg::ST_MEAS]  <= (pst_reg == cpm_pkg::PST_MEAS);
				end
				default: begin
					rdata_reg <= 32'h0000_0000;  // unmapped
				end
			endcase
		end else begin
			rdata_reg <= 32'h0000_0000;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign reg_rdata  = rdata_reg;
	assign strm_valid = strm_valid_reg;
	assign strm_data  = strm_data_reg;
	assign armed_out  = armed_reg;
endmodule : cpm_counter

// File: tb/cpm_counter_sva.sv
// concurrent checks on the counter channel ports
`timescale 1ns/1ps
module cpm_counter_sva (
	input wire logic        sys_clk,
	input wire logic        rst,
	input wire logic [7:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic        gate_in,
	input wire logic        source_in,
	input wire logic        enc_a,
	input wire logic        enc_b,
	input wire logic        enc_z,
	input wire logic        strm_ready,
	input wire logic        strm_valid,
	input wire logic [31:0] strm_data,
	input wire logic        armed_out
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// ************************************************************
	// register port and arming
	// ************************************************************
	rdata_idle_a: assert property (reg_rdata != 32'h0 |-> $past(reg_rd))
		else $error("read data outside a read answer cycle");
	arm_set_a: assert property (reg_wr && reg_addr == cpm_pkg::ADDR_ARM && reg_wdata[0] |=> armed_out)
		else $error("arm write did not arm");
	disarm_a: assert property (reg_wr && reg_addr == cpm_pkg::ADDR_ARM && !reg_wdata[0] && reg_wdata[1]
		|=> !armed_out)
		else $error("disarm write left counter armed");
	status_armed_a: assert property (reg_rd && reg_addr == cpm_pkg::ADDR_STATUS
		|=> reg_rdata[0] == $past(armed_out))
		else $error("status armed bit differs from armed output");
	unmapped_rd_a: assert property (reg_rd && reg_addr > 8'h14 |=> reg_rdata == 32'h0)
		else $error("unmapped read not zero");
	ctrl_rb_a: assert property (reg_wr && reg_addr == cpm_pkg::ADDR_CTRL ##2 reg_rd && reg_addr == cpm_pkg::ADDR_CTRL
		|=> (reg_rdata & 32'h3ff) == ($past(reg_wdata, 3) & 32'h3ff))
		else $error("control readback mismatch");
	reload_rb_a: assert property (reg_wr && reg_addr == cpm_pkg::ADDR_RELOAD ##2 reg_rd
		&& reg_addr == cpm_pkg::ADDR_RELOAD |=> reg_rdata == $past(reg_wdata, 3))
		else $error("reload readback mismatch");
	// ************************************************************
	// stream
	// ************************************************************
	strm_hold_a: assert property (strm_valid && !strm_ready |=> strm_valid && $stable(strm_data))
		else $error("stream word lost before acceptance");
endmodule : cpm_counter_sva

bind cpm_counter cpm_counter_sva u_cpm_counter_sva (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gate_in(gate_in),
	.source_in(source_in), .enc_a(enc_a), .enc_b(enc_b), .enc_z(enc_z), .strm_ready(strm_ready),
	.strm_valid(strm_valid), .strm_data(strm_data), .armed_out(armed_out));

// File: tb/cpm_enc_model.sv
// quadrature and two-pulse encoder model driving the counter pins
`timescale 1ns/1ps
module cpm_enc_model (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic two_pulse,
	input wire logic step_up,
	input wire logic step_dn,
	input wire logic z_on,
	output logic     enc_a,
	output logic     enc_b,
	output logic     enc_z
);
	logic [1:0] phase_reg;
	logic [2:0] pa_reg;
	logic [2:0] pb_reg;
	// quadrature walk, 00-10-11-01 is the upward direction
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			phase_reg <= 2'h0;
		end else if (!two_pulse && step_up) begin
			phase_reg <= phase_reg + 2'h1;
		end else if (!two_pulse && step_dn) begin
			phase_reg <= phase_reg - 2'h1;
		end
	end
	// two-pulse bursts, three cycles high each
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pa_reg <= 3'h0;
			pb_reg <= 3'h0;
		end else begin
			pa_reg <= (two_pulse && step_up) ? 3'h3 : ((pa_reg != 3'h0) ? pa_reg - 3'h1 : 3'h0);
			pb_reg <= (two_pulse && step_dn) ? 3'h3 : ((pb_reg != 3'h0) ? pb_reg - 3'h1 : 3'h0);
		end
	end
	// channel levels
	assign enc_a = two_pulse ? (pa_reg != 3'h0) : (phase_reg == 2'h1 || phase_reg == 2'h2);
	assign enc_b = two_pulse ? (pb_reg != 3'h0) : phase_reg[1];
	// index held high across the whole all-low phase
	assign enc_z = z_on && !two_pulse && phase_reg == 2'h0;
endmodule : cpm_enc_model

// File: tb/tb_cpm_counter.sv
// self-checking bench for the counter channel
`timescale 1ns/1ps
module tb_cpm_counter;
	typedef struct packed {logic [1:0] mode; logic [1:0] dec; int n_up; int n_dn; logic [31:0] exp;} cpm_row_t;
	logic        sys_clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        gate_in = 1'b0;
	logic        source_in = 1'b0;
	logic        strm_ready = 1'b1;
	logic        two_pulse = 1'b0;
	logic        step_up = 1'b0;
	logic        step_dn = 1'b0;
	logic        z_on = 1'b0;
	logic [31:0] reg_rdata, strm_data, d;
	logic        enc_a, enc_b, enc_z, strm_valid, armed_out;
	int          n_fail = 0;
	int          n_compared = 0;
	cpm_row_t    rows[5] = '{'{2'h1, 2'h0, 8, 4, 32'h1}, '{2'h1, 2'h0, 0, 8, 32'hffff_fffe},
		'{2'h1, 2'h1, 8, 0, 32'h4}, '{2'h1, 2'h2, 4, 8, 32'hffff_fffc}, '{2'h2, 2'h0, 3, 5, 32'hffff_fffe}};

	// ************************************************************
	// clock, design and encoder
	// ************************************************************
	always #12.5 sys_clk = ~sys_clk;
	cpm_counter u_cpm_counter (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gate_in(gate_in), .source_in(source_in),
		.enc_a(enc_a), .enc_b(enc_b), .enc_z(enc_z), .strm_ready(strm_ready), .strm_valid(strm_valid),
		.strm_data(strm_data), .armed_out(armed_out));
	cpm_enc_model u_cpm_enc_model (.sys_clk(sys_clk), .rst(rst), .two_pulse(two_pulse), .step_up(step_up),
		.step_dn(step_dn), .z_on(z_on), .enc_a(enc_a), .enc_b(enc_b), .enc_z(enc_z));

	// ************************************************************
	// tasks, each entered just after a rising edge
	// ************************************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		@(posedge sys_clk); // idle edge keeps two write strobes apart
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
		@(posedge sys_clk);
	endtask : rd
	task automatic step(input logic up, input int n);
		repeat (n) begin
			step_up <= up;
			step_dn <= !up;
			@(posedge sys_clk);
			step_up <= 1'b0;
			step_dn <= 1'b0;
			repeat (7) @(posedge sys_clk);
		end
	endtask : step
	task automatic gpulse;
		repeat (2) begin
			gate_in <= !gate_in;
			repeat (3) @(posedge sys_clk);
		end
	endtask : gpulse
	task automatic period_run(input logic gf, input logic sf, input int n);
		gate_in <= gf; // idle level, active edge leaves it
		source_in <= sf;
		repeat (6) @(posedge sys_clk);
		wr(cpm_pkg::ADDR_CTRL, {26'h0, sf, gf, 4'h0});
		wr(cpm_pkg::ADDR_ARM, 32'h1);
		gpulse();
		repeat (n) begin
			source_in <= !sf;
			repeat (3) @(posedge sys_clk);
			source_in <= sf;
			repeat (3) @(posedge sys_clk);
		end
		gpulse();
		repeat (4) @(posedge sys_clk);
		rd(cpm_pkg::ADDR_PERIOD, d);
		chk(d, 32'(n));
		chk({31'h0, armed_out}, 32'h0);
		rd(cpm_pkg::ADDR_STATUS, d);
		chk(d & 32'h2, 32'h2);
	endtask : period_run
	task automatic wait_word(input logic [31:0] exp);
		#1; // look at the stream after the edge has settled
		for (int i = 0; i < 20 && strm_valid !== 1'b1; i++) begin
			@(posedge sys_clk);
			#1;
		end
		chk({31'h0, strm_valid}, 32'h1);
		chk(strm_data, exp);
		@(posedge sys_clk);
	endtask : wait_word
	task automatic wrap_up;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : wrap_up

	// watchdog well beyond the few hundred cycles used
	initial begin
		repeat (20000) @(posedge sys_clk);
		n_fail++;
		wrap_up();
	end

	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (4) @(posedge sys_clk);
		// reset state, unmapped read, control readback
		rd(cpm_pkg::ADDR_CTRL, d);
		chk(d, 32'h0);
		rd(cpm_pkg::ADDR_STATUS, d);
		chk(d, 32'h0);
		rd(8'h20, d);
		chk(d, 32'h0);
		wr(cpm_pkg::ADDR_CTRL, 32'h9);
		rd(cpm_pkg::ADDR_CTRL, d);
		chk(d, 32'h9);
		// no counting before arming
		wr(cpm_pkg::ADDR_ARM, 32'h2);
		step(1'b1, 4);
		rd(cpm_pkg::ADDR_COUNT, d);
		chk(d, 32'h0);
		// decode table
		foreach (rows[i]) begin
			two_pulse <= (rows[i].mode == 2'h2);
			wr(cpm_pkg::ADDR_CTRL, {28'h0, rows[i].dec, rows[i].mode});
			wr(cpm_pkg::ADDR_ARM, 32'h1);
			rd(cpm_pkg::ADDR_STATUS, d);
			chk(d & 32'h1, 32'h1);
			step(1'b1, rows[i].n_up);
			step(1'b0, rows[i].n_dn);
			rd(cpm_pkg::ADDR_COUNT, d);
			chk(d, rows[i].exp);
		end
		two_pulse <= 1'b0;
		// index reload: step into the all-low phase, then resume
		wr(cpm_pkg::ADDR_RELOAD, 32'h0000_0100);
		rd(cpm_pkg::ADDR_RELOAD, d);
		chk(d, 32'h0000_0100);
		wr(cpm_pkg::ADDR_CTRL, 32'h89);
		wr(cpm_pkg::ADDR_ARM, 32'h1);
		z_on <= 1'b1;
		step(1'b1, 4);
		rd(cpm_pkg::ADDR_COUNT, d);
		chk(d, 32'h0000_0100);
		z_on <= 1'b0;
		step(1'b1, 1);
		rd(cpm_pkg::ADDR_COUNT, d);
		chk(d, 32'h0000_0101);
		// period on rising then on falling edges
		period_run(1'b0, 1'b0, 5);
		period_run(1'b1, 1'b1, 3);
		// buffered position sampled on falling gate, slow host
		strm_ready <= 1'b0;
		wr(cpm_pkg::ADDR_CTRL, 32'h59);
		wr(cpm_pkg::ADDR_ARM, 32'h1);
		step(1'b1, 2);
		gpulse();
		wait_word(32'h2);
		step(1'b1, 2);
		chk(strm_data, 32'h2);
		@(posedge sys_clk);
		strm_ready <= 1'b1;
		@(posedge sys_clk);
		strm_ready <= 1'b0;
		gpulse();
		wait_word(32'h4);
		strm_ready <= 1'b1;
		repeat (4) @(posedge sys_clk);
		wrap_up();
	end
endmodule : tb_cpm_counter
